// >>> include/alu_sxt_pkg.sv
// package for the sign-extend / test / exclusive-or / byte-swap datapath
// assumes a 16-bit core with a status word holding n, z, c, v and mode bits
package alu_sxt_pkg;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned BYTE_W = 8;

	// field positions
	localparam int unsigned WORD_MSB = 15;
	localparam int unsigned BYTE_MSB = 7;
	localparam int unsigned HIGH_LSB = 8;

	// constants of the compare-with-zero sum
	localparam logic [15:0] WORD_ONES = 16'hffff;
	localparam logic [7:0]  BYTE_ONES = 8'hff;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  BYTE_FILL = 8'hff;

	// operation select
	typedef enum logic [1:0] {
		OP_BYTE_SWAP,
		OP_SIGN_EXTEND,
		OP_ZERO_COMPARE,
		OP_XOR
	} alu_op_type;

	// arithmetic flags and mode bits of the status word
	typedef struct packed {
		logic oscillator_off_bit;
		logic processor_off_bit;
		logic global_interrupt_enable_bit;
		logic v;
		logic n;
		logic z;
		logic c;
	} status_type;

	// one request to the unit
	typedef struct packed {
		alu_op_type  op;
		logic        byte_mode;
		logic [15:0] src;
		logic [15:0] dst;
		status_type  status;
	} alu_req_type;

	localparam status_type STATUS_RESET = '0;
	localparam logic [15:0] DATA_RESET = 16'h0000;

endpackage

// >>> rtl/alu_sxt_unit.sv
// execution slice: byte swap, sign extend, zero compare, exclusive or
// assumes the core presents one request per enabled clock with i_valid
`timescale 1ns/100ps
`default_nettype none

module alu_sxt_unit
	import alu_sxt_pkg::*;
(
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_ce,
	input  wire logic                     i_valid,
	input  wire alu_sxt_pkg::alu_req_type i_req,
	output logic                          o_valid,
	output logic                          o_dst_write,
	output logic [15:0]                   o_result,
	output alu_sxt_pkg::status_type       o_status
);
	import alu_sxt_pkg::*;

	// operand views
	wire logic [15:0] dst    = i_req.dst;
	wire logic [15:0] src    = i_req.src;
	wire logic [7:0]  dst_lo = dst[BYTE_MSB:0];
	wire logic [7:0]  dst_hi = dst[WORD_MSB:HIGH_LSB];
	wire logic [7:0]  src_lo = src[BYTE_MSB:0];
	wire logic        bmode  = i_req.byte_mode;

	// sign extend and byte swap
	wire logic [15:0] sxt_res = {{BYTE_W{dst[BYTE_MSB]}}, dst_lo};
	wire logic [15:0] swp_res = {dst_lo, dst_hi};

	// compare with zero as a sum, carry out always set
	wire logic [16:0] tst_wsum = {1'b0, dst} + {1'b0, WORD_ONES}
		+ 17'h00001;
	wire logic [8:0]  tst_bsum = {1'b0, dst_lo} + {1'b0, BYTE_ONES}
		+ 9'h001;
	wire logic        tst_neg  = bmode ? dst[BYTE_MSB] : dst[WORD_MSB];
	wire logic        tst_zero = bmode ? (tst_bsum[BYTE_MSB:0] == BYTE_ZERO)
		: (tst_wsum[WORD_MSB:0] == WORD_ZERO);
	wire logic        tst_cy   = bmode ? tst_bsum[BYTE_W]
		: tst_wsum[DATA_W];

	// exclusive or, byte form clears the high byte
	wire logic [15:0] xor_w   = src ^ dst;
	wire logic [15:0] xor_res = bmode ? {BYTE_ZERO, xor_w[BYTE_MSB:0]}
		: xor_w;
	wire logic        xor_neg = bmode ? xor_w[BYTE_MSB] : xor_w[WORD_MSB];
	wire logic        xor_z   = bmode ? (xor_w[BYTE_MSB:0] == BYTE_ZERO)
		: (xor_w == WORD_ZERO);
	wire logic        xor_v   = bmode ? (src_lo[BYTE_MSB] & dst_lo[BYTE_MSB])
		: (src[WORD_MSB] & dst[WORD_MSB]);

	wire logic        sxt_z   = (sxt_res == WORD_ZERO);

	// result and flag selection
	status_type  next_status;
	logic [15:0] next_result;
	logic        next_write;

	always_comb begin
		next_status = i_req.status;
		next_result = dst;
		next_write  = 1'b0;
		case (i_req.op)
			OP_BYTE_SWAP: begin
				next_result = swp_res;
				next_write  = 1'b1;
			end
			OP_SIGN_EXTEND: begin
				next_result   = sxt_res;
				next_write    = 1'b1;
				next_status.n = sxt_res[WORD_MSB];
				next_status.z = sxt_z;
				next_status.c = ~sxt_z;
				next_status.v = 1'b0;
			end
			OP_ZERO_COMPARE: begin
				next_result   = dst;
				next_write    = 1'b0;
				next_status.n = tst_neg;
				next_status.z = tst_zero;
				next_status.c = tst_cy;
				next_status.v = 1'b0;
			end
			OP_XOR: begin
				next_result   = xor_res;
				next_write    = 1'b1;
				next_status.n = xor_neg;
				next_status.z = xor_z;
				next_status.c = ~xor_z;
				next_status.v = xor_v;
			end
			default: begin
				next_result = dst;
			end
		endcase
	end

	// registered outputs
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_valid     <= 1'b0;
			o_dst_write <= 1'b0;
			o_result    <= DATA_RESET;
			o_status    <= STATUS_RESET;
		end else if (i_ce) begin
			o_valid     <= i_valid;
			o_dst_write <= i_valid & next_write;
			if (i_valid) begin
				o_result <= next_result;
				o_status <= next_status;
			end
		end
	end

	// checks, each one clock after the cycle that triggers it, whether or not that clock is enabled

	// sign extend result: low byte kept, bit 7 fills the high byte
	AST_SXT_RES: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_SIGN_EXTEND) |=>
		(o_dst_write && o_result == {{BYTE_W{$past(i_req.dst[BYTE_MSB])}},
		$past(i_req.dst[BYTE_MSB:0])}))
		else $error("sign extend result wrong");

	// sign extend flags follow the result, overflow cleared
	AST_SXT_FLAGS: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_SIGN_EXTEND) |=>
		(o_status.c == !o_status.z && !o_status.v
		&& o_status.n == o_result[WORD_MSB]
		&& o_status.z == (o_result == WORD_ZERO)))
		else $error("sign extend flags wrong");

	// test never writes back and hands the destination through
	AST_TST_KEEP: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_ZERO_COMPARE) |=>
		(!o_dst_write && o_result == $past(i_req.dst)))
		else $error("test modified destination");

	// word test flags: carry set, overflow clear, n and z from dst
	AST_TST_FLAGS: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_ZERO_COMPARE && !i_req.byte_mode)
		|=> (o_status.c && !o_status.v
		&& o_status.n == $past(i_req.dst[WORD_MSB])
		&& o_status.z == ($past(i_req.dst) == WORD_ZERO)))
		else $error("test flags wrong");

	// byte test looks at the low byte only
	AST_TSTB_FLAGS: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_ZERO_COMPARE && i_req.byte_mode)
		|=> (o_status.c && !o_status.v
		&& o_status.n == $past(i_req.dst[BYTE_MSB])
		&& o_status.z == ($past(i_req.dst[BYTE_MSB:0]) == BYTE_ZERO)))
		else $error("byte test flags wrong");

	// word xor result, sign and carry
	AST_XOR_RES: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_XOR && !i_req.byte_mode) |=>
		(o_dst_write && o_result == ($past(i_req.src) ^ $past(i_req.dst))
		&& o_status.n == o_result[WORD_MSB]
		&& o_status.c == (o_result != WORD_ZERO)))
		else $error("xor result or carry wrong");

	// word xor overflow only when both operands are negative
	AST_XOR_V: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_XOR && !i_req.byte_mode) |=>
		o_status.v == ($past(i_req.src[WORD_MSB])
		&& $past(i_req.dst[WORD_MSB])))
		else $error("xor overflow wrong");

	// byte xor: low byte result, high byte cleared, byte-wide flags
	AST_XORB: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_XOR && i_req.byte_mode) |=>
		(o_dst_write && o_result == {BYTE_ZERO,
		$past(i_req.src[BYTE_MSB:0]) ^ $past(i_req.dst[BYTE_MSB:0])}
		&& o_status.n == o_result[BYTE_MSB]
		&& o_status.c == (o_result[BYTE_MSB:0] != BYTE_ZERO)
		&& o_status.v == ($past(i_req.src[BYTE_MSB])
		&& $past(i_req.dst[BYTE_MSB]))))
		else $error("byte xor wrong");

	// mode bits pass through untouched
	AST_MODE: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid) |=>
		(o_status.oscillator_off_bit
		== $past(i_req.status.oscillator_off_bit)
		&& o_status.processor_off_bit
		== $past(i_req.status.processor_off_bit)
		&& o_status.global_interrupt_enable_bit
		== $past(i_req.status.global_interrupt_enable_bit)))
		else $error("mode bits changed");

	// byte swap exchanges bytes and leaves every status bit alone
	AST_SWP: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && i_valid && i_req.op == OP_BYTE_SWAP) |=>
		(o_dst_write
		&& o_result == {$past(i_req.dst[BYTE_MSB:0]),
		$past(i_req.dst[WORD_MSB:HIGH_LSB])}
		&& o_status == $past(i_req.status)))
		else $error("byte swap wrong");

	// strobes follow the accepted request for one enabled cycle
	AST_STROBES: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce |=> (o_valid == $past(i_valid)
		&& o_dst_write == ($past(i_valid)
		&& $past(i_req.op) != OP_ZERO_COMPARE)))
		else $error("valid or write strobe wrong");

	// a low clock enable freezes every output
	AST_CE_HOLD: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_ce |=> ($stable(o_valid) && $stable(o_dst_write)
		&& $stable(o_result) && $stable(o_status)))
		else $error("outputs moved with clock enable low");

	// with no request the result and status words stand
	AST_IDLE_HOLD: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_ce && !i_valid) |=> ($stable(o_result) && $stable(o_status)))
		else $error("result moved without a request");

endmodule

`default_nettype wire

// >>> sim/testbench.sv
// bench for the swap / sign extend / test / xor slice
// assumes alu_sxt_pkg compiled first; inputs move at falling edges
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import alu_sxt_pkg::*;
	logic        i_sys_clk   = 1'b0;
	logic        i_rst_n     = 1'b0;
	logic        i_ce        = 1'b1;
	logic        i_valid     = 1'b0;
	alu_req_type i_req       = '0;
	logic        o_valid;
	logic        o_dst_write;
	logic [15:0] o_result;
	status_type  o_status;
	integer      err_count   = 0;
	integer      n_tests     = 0;
	integer      seed        = 54;
	integer      cycles      = 0;
	logic [15:0] e_res       = '0;
	status_type  e_st        = '0;
	logic        e_vld       = 1'b0;
	logic        e_wr        = 1'b0;
	alu_req_type q;

	alu_sxt_unit DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_ce(i_ce), .i_valid(i_valid), .i_req(i_req), .o_valid(o_valid),
		.o_dst_write(o_dst_write), .o_result(o_result), .o_status(o_status));

	// 50 MHz clock
	always #10 i_sys_clk = ~i_sys_clk;

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// reference result and flags of one accepted request
	task automatic model(input alu_req_type r);
		integer      w;
		logic [15:0] v;
		w = (r.byte_mode && r.op inside {OP_ZERO_COMPARE, OP_XOR}) ? 8 : 16;
		e_st = r.status;
		case (r.op)
			OP_BYTE_SWAP:   v = {r.dst[7:0], r.dst[15:8]};
			OP_SIGN_EXTEND: v = {{8{r.dst[7]}}, r.dst[7:0]};
			OP_ZERO_COMPARE: v = r.dst;
			default:        v = r.src ^ r.dst;
		endcase
		if (w == 8 && r.op == OP_XOR) v[15:8] = 8'h00;
		e_res = v;
		if (r.op != OP_BYTE_SWAP) begin
			e_st.n = v[w-1];
			e_st.z = (w == 8) ? v[7:0] == 8'h00 : v == 16'h0000;
			e_st.c = !e_st.z || r.op == OP_ZERO_COMPARE;
			e_st.v = r.op == OP_XOR && r.src[w-1] && r.dst[w-1];
		end
	endtask

	// model steps on each rising edge; cycle ceiling cuts a hang
	always @(posedge i_sys_clk) begin
		cycles = cycles + 1;
		if (!i_rst_n) begin
			e_res = '0;
			e_st = '0;
			e_vld = 1'b0;
			e_wr = 1'b0;
		end else if (i_ce) begin
			e_vld = i_valid;
			e_wr = i_valid && i_req.op != OP_ZERO_COMPARE;
			if (i_valid) model(i_req);
		end
		if (cycles == 3000) begin
			err_count = err_count + 1;
			end_sim();
		end
	end

	// compare settled outputs, then drive the next request
	task automatic step(input logic v, input alu_req_type r, input logic ce);
		@(negedge i_sys_clk);
		check("result", o_result, e_res);
		check("status", {9'h000, o_status}, {9'h000, e_st});
		check("valid", {15'h0, o_valid}, {15'h0, e_vld});
		check("dst_write", {15'h0, o_dst_write}, {15'h0, e_wr});
		i_valid = v;
		i_req = r;
		i_ce = ce;
	endtask

	// directed corner cases, back to back
	alu_req_type dir_q[$] = '{
		'{OP_XOR, 1'b0, 16'h00ff, 16'h0f0f, 7'h00},
		'{OP_SIGN_EXTEND, 1'b1, 16'h0000, 16'h3480, 7'h7f},
		'{OP_SIGN_EXTEND, 1'b0, 16'h0000, 16'hff00, 7'h70},
		'{OP_ZERO_COMPARE, 1'b0, 16'h0000, 16'h0000, 7'h50},
		'{OP_ZERO_COMPARE, 1'b1, 16'h0000, 16'h1280, 7'h00},
		'{OP_XOR, 1'b0, 16'h8000, 16'hffff, 7'h00},
		'{OP_XOR, 1'b1, 16'h1281, 16'h3480, 7'h20},
		'{OP_BYTE_SWAP, 1'b0, 16'h0000, 16'h40bf, 7'h55}};

	initial begin
		repeat (12) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		foreach (dir_q[k]) step(1'b1, dir_q[k], 1'b1);
		step(1'b0, '0, 1'b1);
		$display("test directed done");
		repeat (800) begin
			q.op = alu_op_type'($random(seed) & 3);
			q.byte_mode = 1'($random(seed));
			q.src = 16'($random(seed));
			q.dst = (($random(seed) & 7) == 0) ? 16'h0 : 16'($random(seed));
			if (($random(seed) & 7) == 0) q.src = q.dst;
			q.status = 7'($random(seed));
			step(($random(seed) & 3) != 0, q, ($random(seed) & 7) != 0);
		end
		step(1'b0, '0, 1'b1);
		$display("test random done");
		end_sim();
	end
endmodule

`default_nettype wire
